// [bench/line_receive_digital_input_tb.sv]
`timescale 1ns/1ps
`include "line_rx_defs.svh"
////////////////////////////////////////////////////////////////////////////////
module line_receive_digital_input_tb;
    localparam logic [31:0] PAT = 32'h5c3a_b5a3;
    localparam int          NP  = ($countones(PAT[15:0]) + 1) / 2;
    localparam int          NN  = $countones(PAT[15:0]) / 2;
    logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_sym_ready;
    logic [3:0]            awaddr, araddr, wstrb;
    logic [31:0]           wdata;
    logic                  awready, wready, bvalid, arready, rvalid, rx_sym_valid, rx_clock_out, clk_prev;
    logic [1:0]            bresp, rresp, rx_line_code;
    logic [31:0]           rdata;
    logic                  ana_a, ana_b, pos_r, neg_r, opt_d, opt_c;
    line_rx_pkg::rx_sym_t  rx_sym;
    line_rx_pkg::rx_sym_t  got_q[$];
    logic [1:0]            mode_of[4] = '{line_rx_pkg::MODE_OPTICAL, line_rx_pkg::MODE_CMI,
                                          line_rx_pkg::MODE_DUAL, line_rx_pkg::MODE_DUAL};
    int                    n_fail, check_count, n_rise, cyc;

    line_receive_digital_input i_dut (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .rx_analog_in_a(ana_a), .rx_analog_in_b(ana_b), .rx_pos_rail(pos_r), .rx_neg_rail(neg_r),
        .rx_optical_data(opt_d), .rx_optical_clock(opt_c), .rx_sym_valid(rx_sym_valid),
        .rx_sym_ready(rx_sym_ready), .rx_sym(rx_sym), .rx_line_code(rx_line_code),
        .rx_clock_out(rx_clock_out));
    line_src_model i_src (
        .rx_analog_in_a(ana_a), .rx_analog_in_b(ana_b), .rx_pos_rail(pos_r), .rx_neg_rail(neg_r),
        .rx_optical_data(opt_d), .rx_optical_clock(opt_c));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Collects symbols the framer side accepts and counts clock rises
    always @(posedge aclk) begin
        if (aresetn && rx_sym_valid && rx_sym_ready) got_q.push_back(rx_sym);
        if (rx_clock_out && !clk_prev) n_rise++;
        clk_prev <= rx_clock_out;
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic check_code(input logic [1:0] g, input logic [1:0] e);
        check_word({30'h0, g}, {30'h0, e});
    endtask
    task automatic check_sym(input line_rx_pkg::rx_sym_t g, input logic [2:0] e);
        check_word({29'h0, g}, {29'h0, e});
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic ta, tw, tb, done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) check_code(bresp, er);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            done = tb;
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        logic ta, tb, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tb = rvalid;
            if (tb) check_word(rdata & m, e);
            if (tb) check_code(rresp, er);
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tb) rready <= 1'b0;
            done = tb;
        end
    endtask
    task automatic set_ctrl(input logic [7:0] c);
        axi_wr(`LRX_CTRL_ADDR, {24'h0, c}, 4'hf, `LRX_RESP_OKAY);
        repeat (40) @(posedge aclk);
        @(negedge aclk);
        got_q.delete();
        n_rise = 0;
    endtask
    function automatic int marks(input logic neg);
        int c;
        c = 0;
        foreach (got_q[i]) c += int'(neg ? got_q[i].neg : got_q[i].pos);
        return c;
    endfunction
    task automatic ami_run(input logic [7:0] c, input logic analog, input int ep, input int en);
        set_ctrl(c);
        i_src.send_ami(PAT, 16, analog);
        repeat (60) @(posedge aclk);
        check_word(32'(marks(1'b0)), 32'(ep));
        check_word(32'(marks(1'b1)), 32'(en));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata} = 40'h0;
        wstrb = 4'hf;
        rx_sym_ready = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`LRX_CTRL_ADDR, 32'h0, 32'hffff_ffff, `LRX_RESP_OKAY);
        rd_chk(`LRX_STAT_ADDR, 32'h0, 32'h3, `LRX_RESP_OKAY);
        rd_chk(4'h8, 32'h0, 32'hffff_ffff, `LRX_RESP_SLVERR);
        axi_wr(4'hc, 32'h1, 4'hf, `LRX_RESP_SLVERR);
        axi_wr(`LRX_CTRL_ADDR, 32'h1, 4'h0, `LRX_RESP_OKAY);
        rd_chk(`LRX_CTRL_ADDR, 32'h0, 32'hffff_ffff, `LRX_RESP_OKAY);
        ami_run(8'h00, 1'b0, 0, 0);
        ami_run(8'h00, 1'b1, NP, NN);
        ami_run(8'h05, 1'b0, NP, NN);
        ami_run(8'h05, 1'b1, 0, 0);
        for (int c = 0; c < 4; c++) begin
            axi_wr(`LRX_CTRL_ADDR, 32'(1 + 2 * c), 4'hf, `LRX_RESP_OKAY);
            rd_chk(`LRX_STAT_ADDR, {30'h0, mode_of[c]}, 32'h3, `LRX_RESP_OKAY);
            check_code(rx_line_code, 2'(c));
        end
        for (int v = 0; v < 2; v++) begin
            set_ctrl(v ? 8'h09 : 8'h01);
            i_src.send_nrz(PAT, 12);
            repeat (20) @(posedge aclk);
            check_word(32'(got_q.size()), 32'd12);
            check_word(32'(n_rise), 32'd12);
            for (int i = 0; i < 12; i++) check_sym(got_q[i], {2'b00, PAT[i] ^ v[0]});
        end
        // Optical clock stays still here, so symbols must come from recovery
        set_ctrl(8'h03);
        i_src.send_cmi_zeros(16);
        repeat (4) @(posedge aclk);
        check_word(32'(got_q.size() >= 12), 32'd1);
        for (int i = 6; i < 12; i++) check_sym(got_q[i], 3'b000);
        // T1 rate: 10 us of free-running recovery spans 15 or 16 bit periods
        set_ctrl(8'h10);
        repeat (1000) @(posedge aclk);
        check_word(32'(n_rise >= 15 && n_rise <= 16), 32'd1);
        set_ctrl(8'h01);
        @(posedge aclk);
        rx_sym_ready <= 1'b0;
        @(negedge aclk);
        i_src.send_nrz(PAT, 20);
        repeat (20) @(posedge aclk);
        rd_chk(`LRX_STAT_ADDR, 32'h107, 32'h1f7, `LRX_RESP_OKAY);
        axi_wr(`LRX_STAT_ADDR, 32'h4, 4'hf, `LRX_RESP_OKAY);
        rd_chk(`LRX_STAT_ADDR, 32'h103, 32'h1f7, `LRX_RESP_OKAY);
        rx_sym_ready <= 1'b1;
        repeat (40) @(posedge aclk);
        check_word(32'(got_q.size()), 32'd17);
        for (int i = 0; i < 17; i++) check_sym(got_q[i], {2'b00, PAT[i]});
        give_verdict();
    end
endmodule // line_receive_digital_input_tb

// [bench/line_src_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module line_src_model #(
    parameter real BIT_NS  = 488.0, // E1 bit period
    parameter real LCLK_NS = 160.0  // Optical link clock period
) (
    output logic rx_analog_in_a,  // Sliced analog, line 1
    output logic rx_analog_in_b,  // Sliced analog, line 2
    output logic rx_pos_rail,     // Positive rail, marks low
    output logic rx_neg_rail,     // Negative rail, marks low
    output logic rx_optical_data, // Optical data
    output logic rx_optical_clock // Optical clock, still between frames
);
    initial begin
        {rx_analog_in_a, rx_analog_in_b} = 2'b00;
        {rx_pos_rail, rx_neg_rail} = 2'b11;
        rx_optical_data = 1'b0;
        rx_optical_clock = 1'b1;
    end
    task automatic send_nrz(input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            rx_optical_data = b[i];
            #(LCLK_NS / 2);
            rx_optical_clock = 1'b0;
            #(LCLK_NS / 2);
            rx_optical_clock = 1'b1;
        end
        // Data is no longer driven valid once the frame ends
        rx_optical_data = ~rx_optical_data;
    endtask
    task automatic send_ami(input logic [31:0] b, input int n, input logic analog);
        logic neg;
        neg = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (b[i]) begin
                if (analog && !neg) rx_analog_in_a = 1'b1;
                if (analog && neg) rx_analog_in_b = 1'b1;
                if (!analog && !neg) rx_pos_rail = 1'b0;
                if (!analog && neg) rx_neg_rail = 1'b0;
                neg = ~neg;
            end
            #(BIT_NS / 2);
            {rx_analog_in_a, rx_analog_in_b} = 2'b00;
            {rx_pos_rail, rx_neg_rail} = 2'b11;
            #(BIT_NS / 2);
        end
    endtask
    task automatic send_cmi_zeros(input int n);
        for (int i = 0; i < n; i++) begin
            rx_optical_data = 1'b0;
            #(BIT_NS / 2);
            rx_optical_data = 1'b1;
            #(BIT_NS / 2);
        end
    endtask
endmodule // line_src_model

// [rtl/line_receive_digital_input.sv]
// Notes on behaviour
// - With the digital mode bit clear, the receive signal comes from the analog receiver inputs.
// - Digital mode bit set with code bit 1 set selects dual-rail reception.
// - In dual-rail mode the positive rail is sampled with the internally recovered clock.
// - In dual-rail mode the negative rail is sampled with the same recovered clock.
// - In dual-rail mode a digital PLL derives the clock from the pulses, no external clock.
// - The invert bit sets input polarity; after reset the rails are active low.
// - The two-bit code select field chooses the receive line coding.
// - Digital mode bit set with code bit 1 clear selects single-rail optical reception.
// - Optical data runs at 2048 or 1544 kbit/s with a 2.048 or 1.544 MHz clock.
// - Optical NRZ data is sampled on the falling edge of the external receive clock.
// - The external receive clock is used only in digital mode with code 00.
// - With CMI code 01 a digital PLL recovers clock and data and the clock pin is ignored.
// - The invert bit also sets the polarity of the optical data input.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "line_rx_defs.svh"

module rx_sym_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    input  wire logic               aclk,      // System clock
    input  wire logic               aresetn,   // Synchronous reset
    input  wire logic               in_valid,  // Write request
    output logic                    in_ready,  // Space available
    input  wire logic [WIDTH-1:0]   in_data,   // Write word
    output logic                    out_valid, // Word available
    input  wire logic               out_ready, // Read accept
    output logic [WIDTH-1:0]        out_data,  // Head word
    output logic [$clog2(DEPTH):0]  level      // Words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        in_ready  = (cnt_q != (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        push      = in_valid & in_ready;
        pop       = out_valid & out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
        cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    assign out_data = mem[rd_q];
    assign level    = cnt_q;
endmodule // rx_sym_fifo

////////////////////////////////////////////////////////////////////////////////

module line_receive_digital_input (
    input  wire logic                aclk,             // 100 MHz system clock
    input  wire logic                aresetn,          // Synchronous reset, low
    input  wire logic                awvalid,          // AXI write address valid
    output logic                     awready,          // AXI write address ready
    input  wire logic [3:0]          awaddr,           // AXI write address
    input  wire logic                wvalid,           // AXI write data valid
    output logic                     wready,           // AXI write data ready
    input  wire logic [31:0]         wdata,            // AXI write data
    input  wire logic [3:0]          wstrb,            // AXI byte strobes
    output logic                     bvalid,           // AXI write response valid
    input  wire logic                bready,           // AXI write response ready
    output logic [1:0]               bresp,            // AXI write response
    input  wire logic                arvalid,          // AXI read address valid
    output logic                     arready,          // AXI read address ready
    input  wire logic [3:0]          araddr,           // AXI read address
    output logic                     rvalid,           // AXI read data valid
    input  wire logic                rready,           // AXI read data ready
    output logic [31:0]              rdata,            // AXI read data
    output logic [1:0]               rresp,            // AXI read response
    input  wire logic                rx_analog_in_a,   // Sliced analog receiver, line 1
    input  wire logic                rx_analog_in_b,   // Sliced analog receiver, line 2
    input  wire logic                rx_pos_rail,      // Dual-rail positive pulses
    input  wire logic                rx_neg_rail,      // Dual-rail negative pulses
    input  wire logic                rx_optical_data,  // Single-rail optical data
    input  wire logic                rx_optical_clock, // External optical receive clock
    output logic                     rx_sym_valid,     // Received symbol available
    input  wire logic                rx_sym_ready,     // Framer takes symbol
    output line_rx_pkg::rx_sym_t     rx_sym,           // Received symbol
    output logic [1:0]               rx_line_code,     // Code select for the decoder
    output logic                     rx_clock_out      // Sampling clock level
);
    localparam int IA = 0, IB = 1, IP = 2, IN = 3, IOD = 4, IOC = 5;
    localparam int NW = `LRX_NCO_W;
    localparam int LW = $clog2(`LRX_FIFO_DEPTH) + 1;

    function automatic line_rx_pkg::rx_mode_t mode_of(line_rx_pkg::ctrl_t c);
        if (!c.digital) begin
            return line_rx_pkg::MODE_ANALOG;
        end else if (c.code[1]) begin
            return line_rx_pkg::MODE_DUAL;
        end else if (c.code[0]) begin
            return line_rx_pkg::MODE_CMI;
        end
        return line_rx_pkg::MODE_OPTICAL;
    endfunction

    function automatic logic [NW-1:0] nco_inc(logic [63:0] bps);
        logic [63:0] v;
        v = (bps << NW) / `LRX_CLK_HZ;
        return v[NW-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage 3 only serves edge detection
    logic [5:0] s1_q, s2_q, s3_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {rx_optical_clock, rx_optical_data, rx_neg_rail,
                     rx_pos_rail, rx_analog_in_b, rx_analog_in_a};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line path
    line_rx_pkg::ctrl_t    ctrl_q, ctrl_d;
    line_rx_pkg::rx_mode_t mode;
    line_rx_pkg::rx_sym_t  sym, psym_q, psym_d;
    logic [NW-1:0] acc_q, acc_d, inc;
    logic p, n, d, mark, mark_q, rise, nco_tick, clk_fall, tick, emit, room;
    logic half_q, half_d, ph_q, ph_d, pend_q, pend_d, ovf_q, ovf_d, ovf_set;
    logic clk_q, clk_d, fin_ready, ovf_clr;
    logic [LW-1:0] level;

    always_comb begin
        mode = mode_of(ctrl_q);
        p = ~(s2_q[IP] ^ ctrl_q.invert);
        n = ~(s2_q[IN] ^ ctrl_q.invert);
        d = s2_q[IOD] ^ ctrl_q.invert;
        if (mode == line_rx_pkg::MODE_ANALOG) begin
            p = s2_q[IA];
            n = s2_q[IB];
        end
        mark = (mode == line_rx_pkg::MODE_CMI) ? d : (p | n);
        rise = mark & ~mark_q;
        // pulse driven recovery at line rate, at twice line rate in CMI
        inc = ctrl_q.t1 ? nco_inc(`LRX_T1_BPS) : nco_inc(`LRX_E1_BPS);
        if (mode == line_rx_pkg::MODE_CMI) begin
            inc = {inc[NW-2:0], 1'b0};
        end
        acc_d    = rise ? '0 : acc_q + inc;
        nco_tick = (acc_q[NW-1:NW-2] == 2'h0) && (acc_d[NW-1:NW-2] == 2'h1);
        // external clock only in optical NRZ
        clk_fall = s3_q[IOC] & ~s2_q[IOC];
        tick     = (mode == line_rx_pkg::MODE_OPTICAL) ? clk_fall : nco_tick;
        emit   = 1'b0;
        sym    = '0;
        half_d = half_q;
        ph_d   = ph_q;
        unique case (mode)
            line_rx_pkg::MODE_ANALOG, line_rx_pkg::MODE_DUAL: begin
                emit = tick;
                sym  = '{viol: 1'b0, neg: n, pos: p};
            end
            line_rx_pkg::MODE_OPTICAL: begin
                emit = tick;
                sym  = '{viol: 1'b0, neg: 1'b0, pos: d};
            end
            line_rx_pkg::MODE_CMI: begin
                if (tick) begin
                    half_d = d;
                    ph_d   = ~ph_q;
                    if (ph_q) begin
                        emit = 1'b1;
                        sym  = '{viol: half_q & ~d, neg: 1'b0, pos: ~(~half_q & d)};
                        ph_d = half_q & ~d;
                    end
                end
            end
        endcase
        // Line cannot stall: one held symbol, then overflow
        room    = ~pend_q | fin_ready;
        pend_d  = (emit & room) | (pend_q & ~fin_ready);
        psym_d  = (emit & room) ? sym : psym_q;
        ovf_set = emit & ~room;
        ovf_d   = ovf_set | (ovf_q & ~ovf_clr);
        clk_d   = (mode == line_rx_pkg::MODE_OPTICAL) ? s2_q[IOC] : ~acc_d[NW-1];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_q  <= '0;
            mark_q <= 1'b0;
            half_q <= 1'b0;
            ph_q   <= 1'b0;
            pend_q <= 1'b0;
            psym_q <= '0;
            ovf_q  <= 1'b0;
            clk_q  <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            mark_q <= mark;
            half_q <= half_d;
            ph_q   <= ph_d;
            pend_q <= pend_d;
            psym_q <= psym_d;
            ovf_q  <= ovf_d;
            clk_q  <= clk_d;
        end
    end

    rx_sym_fifo #(.WIDTH($bits(line_rx_pkg::rx_sym_t)), .DEPTH(`LRX_FIFO_DEPTH)) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (pend_q),
        .in_ready  (fin_ready),
        .in_data   (psym_q),
        .out_valid (rx_sym_valid),
        .out_ready (rx_sym_ready),
        .out_data  (rx_sym),
        .level     (level)
    );
    assign rx_clock_out = clk_q;
    assign rx_line_code = ctrl_q.code;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d, do_wr;
    logic [3:0]  awa_q, awa_d, ws_q, ws_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;

    always_comb begin
        awready = ~aw_q;
        wready  = ~w_q;
        arready = ~rv_q;
        aw_d = aw_q | awvalid;
        awa_d = (awvalid & ~aw_q) ? awaddr : awa_q;
        w_d  = w_q | wvalid;
        wd_d = (wvalid & ~w_q) ? wdata : wd_q;
        ws_d = (wvalid & ~w_q) ? wstrb : ws_q;
        do_wr = aw_q & w_q & ~bv_q;
        bv_d = bv_q & ~bready;
        br_d = br_q;
        ctrl_d  = ctrl_q;
        ovf_clr = 1'b0;
        if (do_wr) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = `LRX_RESP_OKAY;
            if (awa_q == `LRX_CTRL_ADDR) begin
                if (ws_q[0]) begin
                    ctrl_d = line_rx_pkg::ctrl_t'(wd_q[`LRX_CTRL_W-1:0]);
                end
            end else if (awa_q == `LRX_STAT_ADDR) begin
                ovf_clr = ws_q[0] & wd_q[`LRX_STAT_OVF_BIT];
            end else begin
                br_d = `LRX_RESP_SLVERR;
            end
        end
        rv_d = rv_q & ~rready;
        rd_d = rd_q;
        rr_d = rr_q;
        if (arvalid & ~rv_q) begin
            rv_d = 1'b1;
            rd_d = '0;
            rr_d = `LRX_RESP_OKAY;
            if (araddr == `LRX_CTRL_ADDR) begin
                rd_d[`LRX_CTRL_W-1:0] = ctrl_q;
            end else if (araddr == `LRX_STAT_ADDR) begin
                rd_d[`LRX_STAT_MODE_LSB +: 2]   = mode;
                rd_d[`LRX_STAT_OVF_BIT]         = ovf_q;
                rd_d[`LRX_STAT_LVL_LSB +: LW]   = level;
            end else begin
                rr_d = `LRX_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= '0;
            ws_q <= '0;
            wd_q <= '0;
            rd_q <= '0;
            br_q <= '0;
            rr_q <= '0;
            ctrl_q <= `LRX_CTRL_RST;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            ws_q <= ws_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            ctrl_q <= ctrl_d;
        end
    end
    assign bvalid = bv_q;
    assign bresp  = br_q;
    assign rvalid = rv_q;
    assign rdata  = rd_q;
    assign rresp  = rr_q;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_analog_pick;
        mode == line_rx_pkg::MODE_ANALOG && emit && room |=>
            psym_q.pos == $past(s2_q[IA]) && psym_q.neg == $past(s2_q[IB]);
    endproperty
    a_analog_pick: assert property (p_analog_pick) else $error("analog inputs not used");
    property p_dual_sel;
        ctrl_q.digital && ctrl_q.code[1] |-> mode == line_rx_pkg::MODE_DUAL;
    endproperty
    a_dual_sel: assert property (p_dual_sel) else $error("dual-rail not selected");
    property p_dual_sample;
        mode == line_rx_pkg::MODE_DUAL && emit && room |=> pend_q &&
            psym_q.pos == $past(~(s2_q[IP] ^ ctrl_q.invert)) && psym_q.neg == $past(~(s2_q[IN] ^ ctrl_q.invert));
    endproperty
    a_dual_sample: assert property (p_dual_sample) else $error("rail sample wrong");
    property p_realign;
        mode != line_rx_pkg::MODE_OPTICAL && rise |=> acc_q == '0 ##1 !nco_tick;
    endproperty
    a_realign: assert property (p_realign) else $error("pll not realigned");
    property p_tick_gap;
        nco_tick |=> !nco_tick [*7];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("pll ticks too close");
    property p_reset_pol;
        $past(!aresetn) |-> !ctrl_q.invert && !ctrl_q.digital;
    endproperty
    a_reset_pol: assert property (p_reset_pol) else $error("reset polarity wrong");
    property p_code_sel;
        ctrl_q.digital && !ctrl_q.code[1] |-> mode == (ctrl_q.code[0] ? line_rx_pkg::MODE_CMI : line_rx_pkg::MODE_OPTICAL);
    endproperty
    a_code_sel: assert property (p_code_sel) else $error("optical mode wrong");
    property p_opt_fall;
        mode == line_rx_pkg::MODE_OPTICAL && s3_q[IOC] && !s2_q[IOC] && room |=>
            pend_q && psym_q.pos == $past(s2_q[IOD] ^ ctrl_q.invert);
    endproperty
    a_opt_fall: assert property (p_opt_fall) else $error("optical sample wrong");
    property p_clk_ignored;
        mode != line_rx_pkg::MODE_OPTICAL |-> tick == nco_tick;
    endproperty
    a_clk_ignored: assert property (p_clk_ignored) else $error("external clock used");
    property p_cmi_viol;
        mode == line_rx_pkg::MODE_CMI && tick && ph_q && half_q && !d && room |=> psym_q.viol ##0 ph_q;
    endproperty
    a_cmi_viol: assert property (p_cmi_viol) else $error("cmi violation missed");
    property p_out_hold;
        rx_sym_valid && !rx_sym_ready |=> rx_sym_valid && $stable(rx_sym);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("symbol output changed");
    property p_ovf_set;
        ovf_set |=> ovf_q ##1 (ovf_q || $past(ovf_clr));
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow lost");

    c_dual: cover property (mode == line_rx_pkg::MODE_DUAL && emit);
    c_opt: cover property (mode == line_rx_pkg::MODE_OPTICAL && emit);
    c_cmi: cover property (mode == line_rx_pkg::MODE_CMI && emit && !sym.viol);
    c_ovf: cover property (ovf_set);
endmodule // line_receive_digital_input

// [rtl/line_rx_defs.svh]
`ifndef LINE_RX_DEFS_SVH
`define LINE_RX_DEFS_SVH

// Register byte offsets
`define LRX_CTRL_ADDR    4'h0
`define LRX_STAT_ADDR    4'h4

// Control fields and reset value
`define LRX_CTRL_W       5
`define LRX_CTRL_RST     5'h00

// Status fields
`define LRX_STAT_MODE_LSB 0
`define LRX_STAT_OVF_BIT  2
`define LRX_STAT_LVL_LSB  4

// AXI responses
`define LRX_RESP_OKAY    2'h0
`define LRX_RESP_SLVERR  2'h2

// Rates: system clock and line bit rates, then NCO width and FIFO depth
`define LRX_CLK_HZ       64'd100000000
`define LRX_E1_BPS       64'd2048000
`define LRX_T1_BPS       64'd1544000
`define LRX_NCO_W        16
`define LRX_FIFO_DEPTH   16

`endif

// [rtl/line_rx_pkg.sv]
package line_rx_pkg;
    // Gray coded along analog -> dual -> optical -> cmi
    typedef enum logic [1:0] {
        MODE_ANALOG  = 2'h0,
        MODE_DUAL    = 2'h1,
        MODE_OPTICAL = 2'h3,
        MODE_CMI     = 2'h2
    } rx_mode_t;

    typedef struct packed {
        logic       t1;
        logic       invert;
        logic [1:0] code;
        logic       digital;
    } ctrl_t;

    typedef struct packed {
        logic viol;
        logic neg;
        logic pos;
    } rx_sym_t;
endpackage
